// file: hdl/sfp_map.vh
// Purpose : Constants for the slave FIFO port
// Assumes : 100 MHz system clock
// Notes   : Included by every design file of the block
`ifndef SFP_MAP_VH
`define SFP_MAP_VH

// ****************************************************************
// Geometry
// ****************************************************************
`define SFP_DW          16
`define SFP_AW          6
`define SFP_DEPTH       64
`define SFP_NFIFO       4
`define SFP_SELW        2
`define SFP_CNTW        7
`define SFP_MW          8

// ****************************************************************
// Timing
// ****************************************************************
`define SFP_CLK_NS      10
`define SFP_FLG_MAX_NS  115
`define SFP_FLG_CYC     (`SFP_FLG_MAX_NS / `SFP_CLK_NS)

// ****************************************************************
// Reset and increment values
// ****************************************************************
`define SFP_PTR_RST     6'h00
`define SFP_CNT_RST     7'h00
`define SFP_ONE_CNT     7'h01
`define SFP_ONE_PTR     6'h01
`define SFP_PKT_RST     8'h00
`define SFP_ONE_PKT     8'h01
`define SFP_SYNC_RST    2'h0

`endif

// file: hdl/sfp_ram.v
// Purpose : Word store for the four endpoint FIFOs
// Assumes : One write and one read port, same clock
// Notes   : Read data leaves from a register
`timescale 1ns/1ps
`include "sfp_map.vh"

module sfp_ram
(
  // Clock
  input  wire                              clk_i,
  // Write port
  input  wire                              we_i,
  input  wire [`SFP_SELW+`SFP_AW-1:0]      waddr_i,
  input  wire [`SFP_DW-1:0]                wdata_i,
  // Read port
  input  wire [`SFP_SELW+`SFP_AW-1:0]      raddr_i,
  output reg  [`SFP_DW-1:0]                rdata_o
);

  reg [`SFP_DW-1:0] mem [0:`SFP_NFIFO*`SFP_DEPTH-1];

  always @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

// file: hdl/sfp_sync.v
// Purpose : Two-stage synchroniser for pin inputs
// Assumes : Inputs are asynchronous to clk_i
// Notes   : First stage feeds only the second stage
`timescale 1ns/1ps
`include "sfp_map.vh"

module sfp_sync
#(
  parameter W = 1
)
(
  // Clock and reset
  input  wire         clk_i,
  input  wire         reset_n_i,
  // Data
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

// file: hdl/sfp_port.v
// Purpose : Slave parallel FIFO port, four endpoint FIFOs, external master
// Assumes : interface_clock slower than clk_i/4; all pins synchronised
// Notes   : Transfers act on rising interface_clock edges found by clk_i
//
// Operation
// [RL1] Output enable only drives prefetched current word
// [RL2] Bus undriven while output enable inactive
// [RL3] Read needs chip select and read strobe
// [RL4] Read edge advances pointer, shows next word
// [RL5] Burst read gives one word per edge
// [RL6] Write needs chip select and write strobe
// [RL7] Master sets data before write edge
// [RL8] Write edge stores word, bumps pointer
// [RL9] Flags updated after each written word
// [RL10] Master sets select 25 ns before edge
// [RL11] Select chooses flags and data immediately
// [RL12] Commit strobe with last word or later
// [RL13] Word on commit edge joins short packet
// [RL14] Master holds select during commit strobe
// [RL15] Auto mode commits at programmed length
// [RL16] Master delays short commit after auto
// [RL17] Async commit strobe low/high 50 ns
// [RL18] Async commit flags within 115 ns
// [RL19] Strobe and flag polarity configurable
// [RL20] Works with chip select tied active
// [RL21] Ignore write when full, read when empty
`timescale 1ns/1ps
`include "sfp_map.vh"

module sfp_port
(
  // Clock and reset
  input  wire                  clk_i,
  input  wire                  reset_n_i,
  // Link pins
  input  wire                  interface_clock_i,
  input  wire                  fifo_chip_select_i,
  input  wire                  fifo_output_enable_i,
  input  wire                  fifo_read_strobe_i,
  input  wire                  fifo_write_strobe_i,
  input  wire                  packet_commit_strobe_i,
  input  wire [`SFP_SELW-1:0]  fifo_select_i,
  input  wire [`SFP_DW-1:0]    fifo_data_i,
  output reg  [`SFP_DW-1:0]    fifo_data_o,
  output reg                   fifo_data_oe_o,
  // Flags to master
  output reg                   fifo_empty_flag_o,
  output reg                   fifo_full_flag_o,
  // Configuration
  input  wire                  strobe_active_high_i,
  input  wire                  flag_active_high_i,
  input  wire                  commit_async_i,
  input  wire                  auto_commit_en_i,
  input  wire [`SFP_CNTW-1:0]  auto_commit_length_i,
  // USB side drain and status
  input  wire [`SFP_NFIFO-1:0] pkt_drain_i,
  output reg  [`SFP_NFIFO-1:0] pkt_pending_o,
  output reg  [`SFP_NFIFO-1:0] pkt_commit_o
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  wire [10:0] pin_s;

  sfp_sync #(.W(11)) u_sync
  (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({interface_clock_i, fifo_chip_select_i,
                 fifo_output_enable_i, fifo_read_strobe_i,
                 fifo_write_strobe_i, packet_commit_strobe_i,
                 fifo_select_i, 3'h0}),
    .q_o       (pin_s)
  );

  wire [`SFP_DW-1:0] data_s;

  sfp_sync #(.W(`SFP_DW)) u_sync_d
  (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (fifo_data_i),
    .q_o       (data_s)
  );

  // Active level of a strobe after polarity selection
  function act;
    input raw;
    input hi;
    begin
      act = hi ? raw : ~raw;
    end
  endfunction

  wire                 interface_clock_s = pin_s[10];
  wire                 cs_a    = act(pin_s[9], strobe_active_high_i); //RL19
  wire                 oe_a    = act(pin_s[8], strobe_active_high_i);
  wire                 rd_a    = act(pin_s[7], strobe_active_high_i);
  wire                 wr_a    = act(pin_s[6], strobe_active_high_i);
  wire                 pe_a    = act(pin_s[5], strobe_active_high_i);
  wire [`SFP_SELW-1:0] sel     = pin_s[4:3];

  reg interface_clock_q;
  reg pe_q;

  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      interface_clock_q <= 1'b0;
      pe_q    <= 1'b0;
    end
    else
    begin
      interface_clock_q <= interface_clock_s;
      pe_q    <= pe_a;
    end
  end

  wire rise = interface_clock_s & ~interface_clock_q;

  // ****************************************************************
  // Per-FIFO state
  // ****************************************************************
  reg [`SFP_AW-1:0]   wptr_q [0:`SFP_NFIFO-1];
  reg [`SFP_AW-1:0]   rptr_q [0:`SFP_NFIFO-1];
  reg [`SFP_CNTW-1:0] cnt_q  [0:`SFP_NFIFO-1];
  reg [`SFP_CNTW-1:0] acc_q  [0:`SFP_NFIFO-1];
  reg [`SFP_MW-1:0]   pkt_q  [0:`SFP_NFIFO-1];

  wire [`SFP_CNTW-1:0] cnt_sel = cnt_q[sel];
  wire full_sel  = (cnt_sel == `SFP_DEPTH);
  wire empty_sel = (cnt_sel == `SFP_CNT_RST);

  // Chip select tied active simply leaves cs_a high
  wire do_wr = rise & cs_a & wr_a & ~full_sel;   //RL6 RL20 RL21 RL7
  wire do_rd = rise & cs_a & rd_a & ~empty_sel;  //RL3 RL21
  // Synchronous commit samples on the edge; async acts on strobe start
  wire do_pe = commit_async_i ? (pe_a & ~pe_q) : (rise & pe_a); //RL12

  genvar g;
  generate
    for (g = 0; g < `SFP_NFIFO; g = g + 1)
    begin : g_fifo
      wire hit   = (sel == g);
      wire wr_g  = do_wr & hit;
      wire rd_g  = do_rd & hit;
      wire [`SFP_CNTW-1:0] acc_n = acc_q[g] +
                            (wr_g ? `SFP_ONE_CNT : `SFP_CNT_RST);
      // Word written on the commit edge is counted in acc_n
      wire man_c  = do_pe & hit & (acc_n != `SFP_CNT_RST); //RL13
      wire auto_c = auto_commit_en_i & wr_g &
                    (acc_n == auto_commit_length_i);       //RL15
      wire commit = man_c | auto_c;
      wire drain  = pkt_drain_i[g] & (pkt_q[g] != `SFP_PKT_RST);

      always @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          wptr_q[g]       <= `SFP_PTR_RST;
          rptr_q[g]       <= `SFP_PTR_RST;
          cnt_q[g]        <= `SFP_CNT_RST;
          acc_q[g]        <= `SFP_CNT_RST;
          pkt_q[g]        <= `SFP_PKT_RST;
          pkt_commit_o[g] <= 1'b0;
          pkt_pending_o[g]<= 1'b0;
        end
        else
        begin
          if (wr_g)
          begin
            wptr_q[g] <= wptr_q[g] + `SFP_ONE_PTR;             //RL8
          end
          if (rd_g)
          begin
            rptr_q[g] <= rptr_q[g] + `SFP_ONE_PTR;             //RL4 RL5
          end
          if (wr_g & ~rd_g)
          begin
            cnt_q[g] <= cnt_q[g] + `SFP_ONE_CNT;               //RL9
          end
          else if (rd_g & ~wr_g)
          begin
            cnt_q[g] <= cnt_q[g] - `SFP_ONE_CNT;
          end
          acc_q[g] <= commit ? `SFP_CNT_RST : acc_n;
          if (commit & ~drain)
          begin
            pkt_q[g] <= pkt_q[g] + `SFP_ONE_PKT;
          end
          else if (drain & ~commit)
          begin
            pkt_q[g] <= pkt_q[g] - `SFP_ONE_PKT;
          end
          pkt_commit_o[g]  <= commit;
          pkt_pending_o[g] <= (pkt_q[g] != `SFP_PKT_RST) | commit;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Storage
  // ****************************************************************
  wire [`SFP_DW-1:0] rd_word;
  wire [`SFP_AW-1:0] rptr_nx = rptr_q[sel] +
                       (do_rd ? `SFP_ONE_PTR : `SFP_PTR_RST);

  // Read address looks one word ahead so the prefetched word is ready
  sfp_ram u_ram
  (
    .clk_i   (clk_i),
    .we_i    (do_wr),
    .waddr_i ({sel, wptr_q[sel]}),
    .wdata_i (data_s),
    .raddr_i ({sel, rptr_nx}),
    .rdata_o (rd_word)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Flags follow select with no strobe; worst case a few clk_i cycles,
  // well inside the async commit bound of SFP_FLG_CYC cycles
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fifo_data_o       <= {`SFP_DW{1'b0}};
      fifo_data_oe_o    <= 1'b0;
      fifo_empty_flag_o <= 1'b0;
      fifo_full_flag_o  <= 1'b0;
    end
    else
    begin
      fifo_data_o       <= rd_word;                         //RL1 RL11
      fifo_data_oe_o    <= oe_a;                            //RL2
      fifo_empty_flag_o <= act(empty_sel, flag_active_high_i); //RL9 RL18
      fifo_full_flag_o  <= act(full_sel, flag_active_high_i);  //RL19
    end
  end

endmodule

// file: tb/sfp_port_monitor.sv
// Purpose: Port level checks for sfp_port
// Assumes: Polarity inputs change only while the link is idle
// Notes: Attached to every sfp_port by the bind below
`timescale 1ns/1ps
`include "sfp_map.vh"
module sfp_port_monitor
(
  // Inputs of the port
  input wire                  clk_i,
  input wire                  reset_n_i,
  input wire                  fifo_chip_select_i,
  input wire                  fifo_output_enable_i,
  input wire                  fifo_read_strobe_i,
  input wire                  packet_commit_strobe_i,
  input wire [`SFP_SELW-1:0]  fifo_select_i,
  input wire                  strobe_active_high_i,
  input wire                  flag_active_high_i,
  input wire                  auto_commit_en_i,
  input wire [`SFP_NFIFO-1:0] pkt_drain_i,
  // Outputs of the port
  input wire                  fifo_data_oe_o,
  input wire                  fifo_empty_flag_o,
  input wire                  fifo_full_flag_o,
  input wire [`SFP_NFIFO-1:0] pkt_pending_o,
  input wire [`SFP_NFIFO-1:0] pkt_commit_o
);
  // ****
  // Pin levels made polarity free
  // ****
  wire cs_a = fifo_chip_select_i == strobe_active_high_i;
  wire oe_a = fifo_output_enable_i == strobe_active_high_i;
  wire rd_a = fifo_read_strobe_i == strobe_active_high_i;
  wire pe_a = packet_commit_strobe_i == strobe_active_high_i;
  wire em_a = fifo_empty_flag_o == flag_active_high_i;
  wire fu_a = fifo_full_flag_o == flag_active_high_i;
  // Select of the previous cycle, so that calm needs no sampled function
  reg [`SFP_SELW-1:0] sel_q;
  always @(posedge clk_i)
  begin
    sel_q <= fifo_select_i;
  end
  wire calm = pkt_drain_i == 0 && sel_q == fifo_select_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_oe_on: assert property (oe_a[*5] |-> fifo_data_oe_o)
    else $error("data enable missing");
  a_oe_off: assert property ((!oe_a)[*5] |-> !fifo_data_oe_o)
    else $error("data enable while off");
  a_commit_pulse: assert property (|pkt_commit_o |=> pkt_commit_o == 0)
    else $error("commit pulse too long");
  a_commit_pend: assert property (|pkt_commit_o |-> |(pkt_commit_o & pkt_pending_o))
    else $error("commit without pending");
  a_commit_cause: assert property (|pkt_commit_o && !auto_commit_en_i |-> $past(pe_a, 4))
    else $error("commit without strobe");
  // Flags are registered, so a polarity change needs one cycle to settle
  a_flags_excl: assert property ($past(reset_n_i, 2) && $stable(flag_active_high_i) |-> !(em_a && fu_a))
    else $error("empty and full together");
  a_idle_flags: assert property ((!cs_a && !pe_a && calm)[*8] |-> $stable({em_a, fu_a}))
    else $error("flags moved while idle");
  a_full_hold: assert property ((fu_a && !rd_a && calm)[*8] |=> fu_a)
    else $error("full flag lost");
endmodule
bind sfp_port sfp_port_monitor u_sfp_port_monitor (.*);

// file: tb/sfp_master_model.sv
// Purpose: External master driving the link pins
// Assumes: Link clock stands still between transfers
// Notes: One call of cyc is one link clock period of 170 ns
`timescale 1ns/1ps
`include "sfp_map.vh"
module sfp_master_model
(
  // Clock and polarity
  input  wire                 clk_i,
  input  wire                 pol_i,
  // Link pins
  output reg                  lclk_o,
  output reg                  cs_o,
  output reg                  oe_o,
  output reg                  rd_o,
  output reg                  wr_o,
  output reg                  pe_o,
  output reg  [`SFP_SELW-1:0] sel_o,
  output reg  [`SFP_DW-1:0]   dat_o
);
  initial {lclk_o, cs_o, oe_o, rd_o, wr_o, pe_o, sel_o, dat_o} = 0;
  task cyc(input c, o, r, w, p, input [1:0] s, input [15:0] d);
    begin
      @(negedge clk_i);
      sel_o = s;
      cs_o = c ~^ pol_i;
      @(negedge clk_i);
      oe_o = o ~^ pol_i;
      rd_o = r ~^ pol_i;
      wr_o = w ~^ pol_i;
      // Commit strobe stands for a whole link period, far above 50 ns
      pe_o = p ~^ pol_i;
      // Released data inverts on each idle call, so every second idle call shows the last word again
      dat_o = w ? d : ~dat_o;
      repeat (7) @(negedge clk_i);
      lclk_o = 1;
      repeat (8) @(negedge clk_i);
      lclk_o = 0;
    end
  endtask
endmodule

// file: tb/sfp_port_tb.sv
// Purpose: Self checking bench for sfp_port
// Assumes: Checks run 8 clk after each rising link edge, past all latency
// Notes: Asynchronous commit mode is left out
`timescale 1ns/1ps
`include "sfp_map.vh"
module sfp_port_tb;
  reg         clk_i = 0;
  reg         reset_n_i = 0;
  reg         pol = 1;
  reg         fpol = 1;
  reg         auto_en = 0;
  reg  [3:0]  drain = 4'h0;
  wire        lclk, cs, oe, rd, wr, pe, doe, emp, ful;
  wire [1:0]  sel;
  wire [15:0] din, dout;
  wire [3:0]  pend;
  integer     err_total = 0;
  integer     cmp_count = 0;
  integer     k;
  always #5 clk_i = ~clk_i;
  sfp_master_model u_sfp_master_model (.clk_i(clk_i), .pol_i(pol),
    .lclk_o(lclk), .cs_o(cs), .oe_o(oe), .rd_o(rd), .wr_o(wr), .pe_o(pe),
    .sel_o(sel), .dat_o(din));
  sfp_port u_sfp_port (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .interface_clock_i(lclk), .fifo_chip_select_i(cs),
    .fifo_output_enable_i(oe), .fifo_read_strobe_i(rd),
    .fifo_write_strobe_i(wr), .packet_commit_strobe_i(pe),
    .fifo_select_i(sel), .fifo_data_i(din), .fifo_data_o(dout),
    .fifo_data_oe_o(doe), .fifo_empty_flag_o(emp), .fifo_full_flag_o(ful),
    .strobe_active_high_i(pol), .flag_active_high_i(fpol),
    .commit_async_i(1'b0), .auto_commit_en_i(auto_en),
    .auto_commit_length_i(7'h02), .pkt_drain_i(drain),
    .pkt_pending_o(pend), .pkt_commit_o());
  task chk(input string nm, input [15:0] seen, exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        err_total = err_total + 1;
        $display("wrong value %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task take(input [3:0] m);
    begin
      drain = m;
      @(negedge clk_i);
      drain = 4'h0;
    end
  endtask
  // Extra write while full must not overwrite the oldest word
  task s_fill;
    begin
      for (k = 0; k < 65; k = k + 1)
        u_sfp_master_model.cyc(1, 0, 0, 1, 0, 2'h2, 16'ha000 + k);
      chk("full", ful, fpol);
      chk("oe", doe, 0);
      u_sfp_master_model.cyc(1, 1, 0, 0, 0, 2'h2, 0);
      chk("prefetch", dout, 16'ha000);
      u_sfp_master_model.cyc(0, 1, 1, 0, 0, 2'h2, 0);
      chk("cs_read", dout, 16'ha000);
      for (k = 1; k < 66; k = k + 1)
      begin
        u_sfp_master_model.cyc(1, 1, 1, 0, 0, 2'h2, 0);
        chk("burst", dout, k < 64 ? 16'ha000 + k : 16'ha000);
      end
      chk("empty", emp, fpol);
    end
  endtask
  task s_commit;
    begin
      u_sfp_master_model.cyc(0, 0, 0, 1, 0, 2'h0, 16'h5555);
      chk("cs_write", emp, fpol);
      u_sfp_master_model.cyc(1, 0, 0, 1, 0, 2'h1, 16'h1111);
      u_sfp_master_model.cyc(1, 0, 0, 1, 1, 2'h1, 16'h2222);
      chk("select", emp, !fpol);
      chk("pending", pend, 4'h2);
      take(4'h2);
      u_sfp_master_model.cyc(1, 0, 0, 0, 1, 2'h1, 0);
      chk("no_empty_pkt", pend, 4'h0);
    end
  endtask
  task s_auto;
    begin
      auto_en = 1;
      u_sfp_master_model.cyc(1, 0, 0, 1, 0, 2'h3, 16'h0303);
      chk("auto1", pend[3], 0);
      u_sfp_master_model.cyc(1, 0, 0, 1, 0, 2'h3, 16'h0304);
      chk("auto2", pend[3], 1);
      take(4'h8);
      u_sfp_master_model.cyc(1, 0, 0, 1, 0, 2'h3, 16'h0305);
      u_sfp_master_model.cyc(1, 0, 0, 0, 1, 2'h3, 0);
      chk("short", pend[3], 1);
      auto_en = 0;
    end
  endtask
  task s_pol;
    begin
      pol = 0;
      fpol = 0;
      u_sfp_master_model.cyc(1, 0, 0, 1, 1, 2'h0, 16'h7777);
      chk("pol_flag", emp, 1);
      chk("pol_pkt", pend[0], 1);
    end
  endtask
  task summarize;
    begin
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (10) @(negedge clk_i);
    chk("reset", {doe, emp, ful, pend}, 0);
    reset_n_i = 1;
    repeat (4) @(negedge clk_i);
    s_fill;
    s_commit;
    s_auto;
    s_pol;
    summarize;
  end
  initial
  begin
    #300000;
    err_total = err_total + 1;
    summarize;
  end
endmodule
